// File: core/hiib_core.sv
// Overview of operation
// - polarity select resets to 1, choosing bidirectional input interpretation.
// - bidirectional open loop brakes only while input is below half scale.
// - bidirectional open loop maps input linearly to signed output around midpoint.
// - bidirectional closed loop outputs nothing up to half, then scales to full.
// - bidirectional closed loop brakes only when feedback asks, ignoring input level.
// - brake gain reduce bit lowers loop gain as braking nears completion.
// - two-bit field picks resonance sampling period 150, 200, 250 or 300 us.
// - select 0 is unidirectional: feedback brakes, input maps 0 to full scale.
`timescale 1ns/100ps
`default_nettype none
`include "hiib_defines.svh"
module hiib_core #(
  parameter int unsigned SAMP_CYC0 = `HIIB_SAMP_US0 * `HIIB_CLK_MHZ,
  parameter int unsigned SAMP_CYC1 = `HIIB_SAMP_US1 * `HIIB_CLK_MHZ,
  parameter int unsigned SAMP_CYC2 = `HIIB_SAMP_US2 * `HIIB_CLK_MHZ,
  parameter int unsigned SAMP_CYC3 = `HIIB_SAMP_US3 * `HIIB_CLK_MHZ
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] input_level,
  input wire logic closed_loop,
  input wire logic fb_brake_req,
  input wire logic brake_near_done,
  output logic signed [8:0] amp_out,
  output logic brake_active,
  output logic gain_reduce,
  output logic sample_tick
);
  hiib_pkg::hiib_state_s st_reg;
  hiib_pkg::hiib_state_s st_next;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [12:0] samp_limit(input logic [1:0] code);
    case (code)
      2'h0: samp_limit = 13'(SAMP_CYC0 - 1);
      2'h1: samp_limit = 13'(SAMP_CYC1 - 1);
      2'h2: samp_limit = 13'(SAMP_CYC2 - 1);
      default: samp_limit = 13'(SAMP_CYC3 - 1);
    endcase
  endfunction

  logic polarity;
  logic signed [8:0] centered;
  assign polarity = st_reg.ctl[`HIIB_POL_BIT];
  assign centered = $signed({1'b0, input_level}) - $signed({1'b0, `HIIB_MID_LEVEL});

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    if (reg_wr && reg_addr == `HIIB_CTL_ADDR) begin
      st_next.ctl = reg_wdata;
    end
    // read data lags the address by one cycle; unmapped reads give zero
    st_next.rdata = (reg_addr == `HIIB_CTL_ADDR) ? st_reg.ctl : 8'h00;
    if (polarity && !closed_loop) begin
      st_next.amp = 9'(centered <<< 1);
      st_next.brake = input_level < `HIIB_MID_LEVEL;
    end else if (polarity) begin
      st_next.amp = (centered > 0) ? 9'(centered <<< 1) : 9'sh000;
      st_next.brake = fb_brake_req;
    end else begin
      // unidirectional gains back the sign bit as magnitude
      st_next.amp = $signed({1'b0, input_level});
      st_next.brake = fb_brake_req;
    end
    st_next.gain_low = st_reg.ctl[`HIIB_GAIN_BIT] && st_next.brake && brake_near_done;
    // a period change applies at once to the running count, which ends at once if already past the new limit
    if (st_reg.cnt >= samp_limit(st_reg.ctl[`HIIB_SAMP_HI:`HIIB_SAMP_LO])) begin
      st_next.cnt = 13'h0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 13'h0001;
      st_next.tick = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.ctl <= `HIIB_CTL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign amp_out = st_reg.amp;
  assign brake_active = st_reg.brake;
  assign gain_reduce = st_reg.gain_low;
  assign sample_tick = st_reg.tick;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // a period written mid-count ends the running gap early or late, so that gap is not judged
  logic [12:0] gap_cnt;
  logic seen_tick;
  logic [1:0] gap_code;
  logic gap_mixed;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_cnt <= 13'h0000;
      seen_tick <= 1'b0;
      gap_code <= 2'h0;
      gap_mixed <= 1'b0;
    end else begin
      gap_cnt <= sample_tick ? 13'h0001 : gap_cnt + 13'h0001;
      seen_tick <= seen_tick | sample_tick;
      gap_code <= st_reg.ctl[`HIIB_SAMP_HI:`HIIB_SAMP_LO];
      gap_mixed <= sample_tick ? 1'b0 : gap_mixed | (st_reg.ctl[`HIIB_SAMP_HI:`HIIB_SAMP_LO] != gap_code);
    end
  end

  reset_pol_a: assert property ($rose(arst_n) |-> st_reg.ctl[`HIIB_POL_BIT])
    else $error("polarity select not set after reset");
  open_brake_a: assert property (polarity && !closed_loop && !reg_wr |=>
    brake_active == ($past(input_level) < 8'h80))
    else $error("open loop brake does not follow input level");
  open_map_a: assert property (polarity && !closed_loop && !reg_wr && input_level == 8'h40 |=>
    amp_out == -9'sd128)
    else $error("quarter input not negative half scale");
  open_mid_a: assert property (polarity && !closed_loop && !reg_wr && input_level == 8'h80 |=>
    amp_out == 9'sd0 && !brake_active)
    else $error("mid input not zero output");
  closed_low_a: assert property (polarity && closed_loop && !reg_wr && input_level <= 8'h80 |=>
    amp_out == 9'sd0)
    else $error("closed loop lower half not silent");
  closed_brake_a: assert property (polarity && closed_loop && !reg_wr |=>
    brake_active == $past(fb_brake_req))
    else $error("closed loop brake not from feedback");
  // the enable bit is judged as it stood when the flag was computed, since a write may land alongside
  gain_low_a: assert property (gain_reduce |-> brake_active && $past(st_reg.ctl[`HIIB_GAIN_BIT]))
    else $error("gain reduced outside braking or while disabled");
  samp_gap_a: assert property (sample_tick && seen_tick && !gap_mixed &&
    $stable(st_reg.ctl[`HIIB_SAMP_HI:`HIIB_SAMP_LO]) |->
    gap_cnt == 13'(samp_limit(st_reg.ctl[`HIIB_SAMP_HI:`HIIB_SAMP_LO]) + 13'h0001))
    else $error("sampling period wrong");
  uni_map_a: assert property (!polarity && !reg_wr |=>
    amp_out == $signed({1'b0, $past(input_level)}) && brake_active == $past(fb_brake_req))
    else $error("unidirectional mapping wrong");

  // ----------------------------------------
  // register checks
  // ----------------------------------------
  reg_write_a: assert property (reg_wr && reg_addr == `HIIB_CTL_ADDR |=>
    st_reg.ctl == $past(reg_wdata))
    else $error("control write not stored");
  reg_other_a: assert property (reg_wr && reg_addr != `HIIB_CTL_ADDR |=>
    $stable(st_reg.ctl))
    else $error("write to other address changed control");
  read_back_a: assert property (reg_addr == `HIIB_CTL_ADDR |=>
    reg_rdata == $past(st_reg.ctl))
    else $error("read data not control value");
  read_zero_a: assert property (reg_addr != `HIIB_CTL_ADDR |=>
    reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  reset_out_a: assert property ($rose(arst_n) |->
    amp_out == 9'sh000 && !brake_active && !sample_tick && !gain_reduce)
    else $error("outputs not cleared by reset");

  // ----------------------------------------
  // datapath end points and three-quarter points
  // ----------------------------------------
  // end points pin the scale; the general checks above would pass a sign slip at full scale
  open_full_a: assert property (polarity && !closed_loop && !reg_wr && input_level == 8'h00 |=>
    amp_out == 9'sh100 && brake_active)
    else $error("zero input not negative full scale");
  open_top_a: assert property (polarity && !closed_loop && !reg_wr && input_level == 8'hff |=>
    amp_out == 9'sh0fe && !brake_active)
    else $error("full input not positive full scale");
  open_three_a: assert property (polarity && !closed_loop && !reg_wr && input_level == 8'hc0 |=>
    amp_out == 9'sh080)
    else $error("three quarter input not positive half scale");
  closed_half_a: assert property (polarity && closed_loop && !reg_wr && input_level == 8'hc0 |=>
    amp_out == 9'sh080)
    else $error("closed loop three quarter not half scale");
  closed_full_a: assert property (polarity && closed_loop && !reg_wr && input_level == 8'hff |=>
    amp_out == 9'sh0fe)
    else $error("closed loop full input not full scale");
  uni_top_a: assert property (!polarity && !reg_wr && input_level == 8'hff |=>
    amp_out == 9'sh0ff)
    else $error("unidirectional full input not full scale");
  uni_zero_a: assert property (!polarity && !reg_wr && input_level == 8'h00 |=>
    amp_out == 9'sh000)
    else $error("unidirectional zero input not silent");

  // ----------------------------------------
  // gain and sampling checks
  // ----------------------------------------
  gain_hold_a: assert property (!brake_near_done |=> !gain_reduce)
    else $error("gain reduced before braking nears completion");
  gain_on_a: assert property (st_reg.ctl[`HIIB_GAIN_BIT] && polarity && !closed_loop && !reg_wr &&
    input_level < 8'h80 && brake_near_done |=> gain_reduce)
    else $error("gain not reduced near end of braking");
  // limits are never below two cycles, so the pulse always drops again
  tick_pulse_a: assert property (sample_tick |=> !sample_tick)
    else $error("sampling tick longer than one cycle");

  open_brake_c: cover property (polarity && !closed_loop ##1 brake_active);
  closed_full_c: cover property (polarity && closed_loop && input_level == 8'hff);
  gain_low_c: cover property (gain_reduce);
  uni_mode_c: cover property (!polarity && sample_tick);
  period_c: cover property (sample_tick && seen_tick && !gap_mixed);
endmodule
`default_nettype wire

// File: core/hiib_defines.svh
`ifndef HIIB_DEFINES_SVH
`define HIIB_DEFINES_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define HIIB_CTL_ADDR 8'h1c
`define HIIB_CTL_RESET 8'hda
`define HIIB_POL_BIT 7
`define HIIB_GAIN_BIT 6
`define HIIB_SAMP_HI 5
`define HIIB_SAMP_LO 4
// ----------------------------------------
// input scale and timing
// ----------------------------------------
`define HIIB_MID_LEVEL 8'h80
`define HIIB_CLK_MHZ 25
`define HIIB_SAMP_US0 150
`define HIIB_SAMP_US1 200
`define HIIB_SAMP_US2 250
`define HIIB_SAMP_US3 300
`endif

// File: core/hiib_pkg.sv
package hiib_pkg;
  typedef struct packed {
    logic [7:0] ctl;
    logic [12:0] cnt;
    logic signed [8:0] amp;
    logic brake;
    logic gain_low;
    logic tick;
    logic [7:0] rdata;
  } hiib_state_s;
endpackage

// File: tb/hiib_host.sv
`timescale 1ns/100ps
`default_nettype none
module hiib_host (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // one-cycle strobe; data inverted after release so stale data cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk, arst_n, reg_wr, closed_loop, fb_brake_req, brake_near_done, brake_active, gain_reduce, sample_tick;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, input_level, rv;
  logic signed [8:0] amp_out;
  logic [7:0] lv [5] = '{8'h00, 8'h40, 8'h80, 8'hc0, 8'hff};
  int error_cnt = 0, compares = 0, n, ea;
  hiib_core #(.SAMP_CYC0(6), .SAMP_CYC1(8), .SAMP_CYC2(10), .SAMP_CYC3(12)) i_hiib_core (.clk(clk),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .input_level(input_level), .closed_loop(closed_loop), .fb_brake_req(fb_brake_req),
    .brake_near_done(brake_near_done), .amp_out(amp_out), .brake_active(brake_active),
    .gain_reduce(gain_reduce), .sample_tick(sample_tick));
  hiib_host i_hiib_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic dp(input logic [7:0] l, input logic c, f, input int a, input logic b, g);
    @(negedge clk);
    input_level = l;
    closed_loop = c;
    fb_brake_req = f;
    @(negedge clk);
    chk("amp", 9'(a), amp_out);
    chk("brake", {8'h00, b}, {8'h00, brake_active});
    chk("gain", {8'h00, g}, {8'h00, gain_reduce});
  endtask
  // bounded wait; n is cycles since the previous pulse
  task automatic tick;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sample_tick !== 1'b1 && n < 100);
  endtask
  initial begin
    #100us;
    error_cnt++;
    stop_test;
  end
  initial begin
    {arst_n, closed_loop, fb_brake_req, input_level} = '0;
    brake_near_done = 1'b1;
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    i_hiib_host.rd(8'h1c, rv);
    chk("ctl", 9'h0da, {1'b0, rv});
    i_hiib_host.wr(8'h1d, 8'h00);
    i_hiib_host.rd(8'h1d, rv);
    chk("unmapped", 9'h000, {1'b0, rv});
    for (int i = 0; i < 5; i++) begin
      ea = (int'(lv[i]) - 128) * 2;
      dp(lv[i], 1'b0, 1'b0, ea, lv[i] < 8'h80, lv[i] < 8'h80);
      dp(lv[i], 1'b1, i[0], ea > 0 ? ea : 0, i[0], i[0]);
    end
    brake_near_done = 1'b0;
    dp(8'h00, 1'b0, 1'b0, -256, 1'b1, 1'b0);
    dp(8'h80, 1'b1, 1'b1, 0, 1'b1, 1'b0);
    brake_near_done = 1'b1;
    // gain bit cleared too, so gain_reduce must stay low while braking; dp keeps closed loop here
    i_hiib_host.wr(8'h1c, 8'h1a);
    for (int i = 0; i < 5; i++) dp(lv[i], 1'b1, i[0], int'(lv[i]), i[0], 1'b0);
    for (int k = 0; k < 4; k++) begin
      tick;
      i_hiib_host.wr(8'h1c, {2'b11, k[1:0], 4'ha});
      tick;
      tick;
      chk("period", 9'(6 + 2 * k), 9'(n));
    end
    stop_test;
  end
endmodule
`default_nettype wire
